// ===== shared/usf_pkg.sv
/*
 * constants, types and helpers shared by the serial port with fifos.
 * assumes one system clock; software side drives plain strobes and ports.
 */
// Contract
// R01 - divisor is 16-bit integer plus 6-bit fraction
// R02 - oversample tick at 16x baud, tx divides by 16
// R03 - software rounds fraction as int(frac*64+0.5)
// R04 - divisor and line control latch together on line write
// R05 - software writes divisors, then line control
// R06 - separate tx and rx enables, both set after reset
// R07 - software disables module before reprogramming control
// R08 - disable finishes the current character first
// R09 - start, data lsb first, parity, stop bits
// R10 - 5 to 8 bits, four parity modes, 1-2 stops
// R11 - frames sent back to back until tx fifo empty
// R12 - busy from tx data until last stop sent
// R13 - start rechecked on eighth tick, false start dropped
// R14 - data sampled every sixteenth tick, then parity
// R15 - stop low gives framing error, word stored with flags
// R16 - overrun, parity, framing, break attached to each word
// R17 - 16-entry fifos, 12-bit read, 8-bit write
// R18 - fifos one deep until fifo enable set; the rx side still holds three words, two more in the read skid
// R19 - empty/full flags and overrun status bit reported
// R20 - per-fifo trigger level, eighths one to seven
// R21 - both trigger levels half after reset
// R22 - generator reaches up to 1.25 Mbit/s
// R23 - sources masked individually, ORed into one request
// R24 - timeout after 32 idle bit times with data waiting
// R25 - clear bit clears raw and masked status
// R26 - loopback routes tx stream into receiver
// R27 - overrun on full rx fifo keeps old contents
package usf_pkg;

	// ----------------------------------------
	// sizes and counts
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int DIV_INT_W = 16;
	localparam int DIV_FRAC_W = 6;
	localparam int FIFO_DEPTH = 16;
	localparam int BUF_DEPTH = 2;
	localparam int OS_RATE = 16;
	localparam int IRQ_N = 7;
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] START_CHECK = 4'h7;
	localparam int RT_BITS = 32;
	localparam int RT_W = 10;
	localparam logic [RT_W-1:0] RT_LAST = RT_W'(RT_BITS * OS_RATE);
	localparam int CLK_HZ = 50_000_000;
	localparam int MAX_BAUD = 1_250_000;
	localparam int MIN_DIV_INT = CLK_HZ / (OS_RATE * MAX_BAUD);

	// ----------------------------------------
	// interrupt source positions
	// ----------------------------------------
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;
	localparam int IRQ_RT = 2;
	localparam int IRQ_FE = 3;
	localparam int IRQ_PE = 4;
	localparam int IRQ_BE = 5;
	localparam int IRQ_OE = 6;

	// ----------------------------------------
	// trigger level codes
	// ----------------------------------------
	localparam logic [2:0] LVL_1_8 = 3'h0;
	localparam logic [2:0] LVL_1_4 = 3'h1;
	localparam logic [2:0] LVL_1_2 = 3'h2;
	localparam logic [2:0] LVL_3_4 = 3'h3;
	localparam logic [2:0] LVL_7_8 = 3'h4;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic stick;
		logic [1:0] wlen;
		logic fifo_en;
		logic two_stop;
		logic even;
		logic par_en;
		logic brk;
	} usf_lcr_s;

	typedef struct packed {
		logic [DIV_INT_W-1:0] div_int;
		logic [DIV_FRAC_W-1:0] div_frac;
		usf_lcr_s lcr;
	} usf_cfg_s;

	typedef struct packed {
		logic loopback;
		logic rx_en;
		logic tx_en;
		logic module_en;
	} usf_ctl_s;

	typedef struct packed {
		logic [2:0] tx_sel;
		logic [2:0] rx_sel;
	} usf_lvl_s;

	typedef struct packed {
		logic brk;
		logic fr;
		logic par;
		logic ovr;
		logic [DATA_W-1:0] data;
	} usf_rxw_s;

	typedef struct packed {
		logic busy;
		logic rx_fifo_full_flag;
		logic tx_fifo_empty_flag;
		logic tx_fifo_full_flag;
		logic rx_fifo_empty_flag;
	} usf_flag_s;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		usf_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
		usf_rx_e;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam usf_cfg_s CFG_RST = '0;
	localparam usf_ctl_s CTL_RST = '{loopback: 1'b0, rx_en: 1'b1,
		tx_en: 1'b1, module_en: 1'b0};
	localparam usf_lvl_s LVL_RST = '{tx_sel: LVL_1_2, rx_sel: LVL_1_2};

	// parity bit for the configured word length and mode
	function automatic logic par_bit(input logic [7:0] d,
		input usf_lcr_s l);
		logic [7:0] m;
		m = d & (8'hff >> (2'd3 - l.wlen));
		if (l.stick)
			par_bit = ~l.even;
		else
			par_bit = l.even ? ^m : ~^m;
	endfunction

endpackage

// ===== src/usf_baud.sv
/*
 * fractional divider giving the 16x oversample tick.
 * assumes the divisor is held steady between line control writes.
 */
`timescale 1ns/1ps
module usf_baud import usf_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// divisor
	input wire logic [DIV_INT_W-1:0] div_int,
	input wire logic [DIV_FRAC_W-1:0] div_frac,
	// tick
	output logic oversample_tick
);
	logic [DIV_INT_W-1:0] cnt_q, cnt_d;
	logic [DIV_FRAC_W-1:0] acc_q, acc_d;
	logic tick_q, tick_d;
	logic [DIV_FRAC_W:0] sum;

	// fraction accumulates in 1/64 steps and stretches a period by one
	always_comb begin
		sum = {1'b0, acc_q} + {1'b0, div_frac}; // see R01
		cnt_d = cnt_q;
		acc_d = acc_q;
		tick_d = 1'b0;
		if (div_int == '0) begin
			cnt_d = '0;
		end else if (cnt_q == '0) begin
			tick_d = 1'b1;
			acc_d = sum[DIV_FRAC_W-1:0];
			cnt_d = div_int - 1'b1 + DIV_INT_W'(sum[DIV_FRAC_W]);
		end else begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cnt_q <= '0;
			acc_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			acc_q <= acc_d;
			tick_q <= tick_d;
		end
	end

	assign oversample_tick = tick_q; // see R02

	// limitation: integer part 1, below MIN_DIV_INT, exceeds the top rate; 0 stops the tick
	chk_tick_spacing: assert property (@(posedge mclk) disable iff (!resetn)
		(tick_q && div_int >= 16'h0002 && $stable(div_int)) |=> !tick_q)
		else $error("ticks closer than divisor"); // see R22
endmodule

// ===== src/usf_fifo.sv
/*
 * show-ahead fifo whose head word sits in an output register.
 * assumes lim never exceeds depth and is lowered only when empty.
 */
`timescale 1ns/1ps
module usf_fifo import usf_pkg::*; #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	parameter int LW = $clog2(DEPTH + 1)
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// usable depth
	input wire logic [LW-1:0] lim,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	// occupancy
	output logic [LW-1:0] level
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [LW-1:0] cnt_q, cnt_d;
	logic ov_q, ov_d, full_q, full_d;
	logic [W-1:0] od_q, od_d;
	logic push, pop, room, take, byp, wr;

	always_comb begin
		push = in_valid & ~full_q;
		pop = ov_q & out_ready;
		room = ~ov_q | pop;
		take = room & (cnt_q != '0);
		byp = room & (cnt_q == '0) & push;
		wr = push & ~byp;
		cnt_d = cnt_q + LW'(wr) - LW'(take);
		ov_d = (take | byp) ? 1'b1 : (pop ? 1'b0 : ov_q);
		od_d = take ? mem_q[rp_q] : (byp ? in_data : od_q);
		wp_d = wp_q;
		if (wr)
			wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
		rp_d = rp_q;
		if (take)
			rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
		// full is registered so the fill side sees a clean ready
		full_d = (cnt_d + LW'(ov_d)) >= lim; // see R18
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
			full_q <= 1'b0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			ov_q <= ov_d;
			od_q <= od_d;
			full_q <= full_d;
		end
		if (wr)
			mem_q[wp_q] <= in_data;
	end

	assign in_ready = ~full_q;
	assign out_valid = ov_q;
	assign out_data = od_q;
	assign level = cnt_q + LW'(ov_q);

	chk_fifo_limit: assert property (@(posedge mclk) disable iff (!resetn)
		full_q |-> ##1 !(level > $past(level))) // see R18
		else $error("fifo grew while full");
endmodule

// ===== src/usf_uart.sv
/*
 * serial transmitter and receiver with fifos, divider and interrupt.
 * assumes software drives plain strobes; serial_rx_in is asynchronous.
 */
`timescale 1ns/1ps
module usf_uart import usf_pkg::*; #(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int LW = $clog2(FIFO_DEPTH + 1)
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// transmit data
	input wire logic tx_wvalid,
	input wire logic [DATA_W-1:0] tx_wdata,
	output logic tx_wready,
	// receive data
	output logic rd_valid,
	output usf_rxw_s rd_word,
	input wire logic rd_ready,
	// configuration writes
	input wire logic int_div_we,
	input wire logic [DIV_INT_W-1:0] int_div_wdata,
	input wire logic frac_div_we,
	input wire logic [DIV_FRAC_W-1:0] frac_div_wdata,
	input wire logic lcr_we,
	input wire usf_lcr_s lcr_wdata,
	input wire logic ctl_we,
	input wire usf_ctl_s ctl_wdata,
	input wire logic lvl_we,
	input wire usf_lvl_s lvl_wdata,
	// interrupts
	input wire logic [IRQ_N-1:0] irq_mask,
	input wire logic [IRQ_N-1:0] irq_clear,
	input wire logic err_clear,
	output logic [IRQ_N-1:0] raw_irq,
	output logic irq,
	// status
	output usf_flag_s flags,
	output logic overrun_status,
	// serial line
	input wire logic serial_rx_in,
	output logic serial_tx_out
);
	// ----------------------------------------
	// control state
	// ----------------------------------------
	usf_cfg_s cfg_q, cfg_d;
	usf_ctl_s ctl_q, ctl_d;
	usf_lvl_s lvl_q, lvl_d;
	logic [DIV_INT_W-1:0] ibrd_q, ibrd_d;
	logic [DIV_FRAC_W-1:0] fbrd_q, fbrd_d;
	logic [LW-1:0] lim;

	always_comb begin
		ibrd_d = int_div_we ? int_div_wdata : ibrd_q;
		fbrd_d = frac_div_we ? frac_div_wdata : fbrd_q;
		cfg_d = cfg_q;
		// divisor writes wait in shadows until the line write
		if (lcr_we)
			cfg_d = '{div_int: ibrd_d, div_frac: fbrd_d,
				lcr: lcr_wdata}; // see R04
		ctl_d = ctl_we ? ctl_wdata : ctl_q; // see R06
		lvl_d = lvl_we ? lvl_wdata : lvl_q;
		lim = cfg_q.lcr.fifo_en ? LW'(DEPTH) : LW'(1); // see R18
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cfg_q <= CFG_RST;
			ctl_q <= CTL_RST;
			lvl_q <= LVL_RST; // see R21
			ibrd_q <= '0;
			fbrd_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			ctl_q <= ctl_d;
			lvl_q <= lvl_d;
			ibrd_q <= ibrd_d;
			fbrd_q <= fbrd_d;
		end
	end

	// ----------------------------------------
	// divider and fifos
	// ----------------------------------------
	logic tick;
	logic txf_ov, rxf_ir, rxf_ov, buf_ir, tx_pop, rxw_v_q;
	logic [DATA_W-1:0] txf_od;
	usf_rxw_s rxw_q, rxf_od;
	logic [LW-1:0] tx_lvl, rx_lvl;

	usf_baud u_baud (
		.mclk(mclk), .resetn(resetn),
		.div_int(cfg_q.div_int), .div_frac(cfg_q.div_frac),
		.oversample_tick(tick)
	);

	usf_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_txf ( // see R17
		.mclk(mclk), .resetn(resetn), .lim(lim),
		.in_valid(tx_wvalid), .in_data(tx_wdata), .in_ready(tx_wready),
		.out_valid(txf_ov), .out_data(txf_od), .out_ready(tx_pop),
		.level(tx_lvl)
	);

	usf_fifo #(.W($bits(usf_rxw_s)), .DEPTH(DEPTH)) u_rxf ( // see R17
		.mclk(mclk), .resetn(resetn), .lim(lim),
		.in_valid(rxw_v_q), .in_data(rxw_q), .in_ready(rxf_ir),
		.out_valid(rxf_ov), .out_data(rxf_od), .out_ready(buf_ir),
		.level(rx_lvl)
	);

	// two-entry skid holds two more words before a reader stall drops one
	usf_fifo #(.W($bits(usf_rxw_s)), .DEPTH(BUF_DEPTH)) u_buf (
		.mclk(mclk), .resetn(resetn), .lim(2'(BUF_DEPTH)),
		.in_valid(rxf_ov), .in_data(rxf_od), .in_ready(buf_ir),
		.out_valid(rd_valid), .out_data(rd_word), .out_ready(rd_ready),
		.level()
	);

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	usf_tx_e tst_q, tst_d;
	logic [DATA_W-1:0] tsh_q, tsh_d;
	logic [3:0] tcnt_q, tcnt_d;
	logic [2:0] tbit_q, tbit_d;
	logic tpar_q, tpar_d, tstop2_q, tstop2_d, txo_q, txo_d, tx_line_q;
	logic tend;

	always_comb begin
		tst_d = tst_q;
		tsh_d = tsh_q;
		tbit_d = tbit_q;
		tpar_d = tpar_q;
		tstop2_d = tstop2_q;
		txo_d = txo_q;
		tcnt_d = tick ? tcnt_q + 4'h1 : tcnt_q;
		tend = tick & (tcnt_q == OS_LAST); // see R02
		// enable only gates the start of a frame; see R08
		tx_pop = (tst_q == TX_IDLE) & txf_ov &
			ctl_q.module_en & ctl_q.tx_en; // see R11
		case (tst_q)
		TX_IDLE: begin
			txo_d = 1'b1;
			if (tx_pop) begin
				tst_d = TX_START;
				tsh_d = txf_od;
				tpar_d = par_bit(txf_od, cfg_q.lcr);
				tcnt_d = '0;
				txo_d = 1'b0; // see R09
			end
		end
		TX_START: if (tend) begin
			tst_d = TX_DATA;
			tbit_d = '0;
			txo_d = tsh_q[0];
		end
		TX_DATA: if (tend) begin
			if (tbit_q == 3'd4 + {1'b0, cfg_q.lcr.wlen}) begin // see R10
				tst_d = cfg_q.lcr.par_en ? TX_PAR : TX_STOP;
				txo_d = cfg_q.lcr.par_en ? tpar_q : 1'b1;
				tstop2_d = cfg_q.lcr.two_stop;
			end else begin
				tbit_d = tbit_q + 3'd1;
				tsh_d = tsh_q >> 1;
				txo_d = tsh_q[1];
			end
		end
		TX_PAR: if (tend) begin
			tst_d = TX_STOP;
			txo_d = 1'b1;
		end
		TX_STOP: if (tend) begin
			if (tstop2_q)
				tstop2_d = 1'b0;
			else
				tst_d = TX_IDLE;
		end
		default: tst_d = TX_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tst_q <= TX_IDLE;
			tsh_q <= '0;
			tcnt_q <= '0;
			tbit_q <= '0;
			tpar_q <= 1'b0;
			tstop2_q <= 1'b0;
			txo_q <= 1'b1;
			tx_line_q <= 1'b1;
		end else begin
			tst_q <= tst_d;
			tsh_q <= tsh_d;
			tcnt_q <= tcnt_d;
			tbit_q <= tbit_d;
			tpar_q <= tpar_d;
			tstop2_q <= tstop2_d;
			txo_q <= txo_d;
			tx_line_q <= txo_d & ~cfg_q.lcr.brk;
		end
	end

	assign serial_tx_out = tx_line_q;

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	usf_rx_e rst_q, rst_d;
	logic [2:0] sync_q;
	logic rl_q, rl_d, rprev_q, rx_in;
	logic [3:0] rcnt_q, rcnt_d;
	logic [2:0] rbit_q, rbit_d;
	logic [DATA_W-1:0] rsh_q, rsh_d;
	logic rpe_q, rpe_d, rpb_q, rpb_d, rxw_v_d, ovr_pend_q, ovr_pend_d;
	usf_rxw_s rxw_d;
	logic rmid;

	always_comb begin
		// the line level changes only once two later stages agree
		rl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : rl_q;
		rx_in = ctl_q.loopback ? tx_line_q : rl_q; // see R26
		rst_d = rst_q;
		rbit_d = rbit_q;
		rsh_d = rsh_q;
		rpe_d = rpe_q;
		rpb_d = rpb_q;
		rxw_v_d = 1'b0;
		rxw_d = rxw_q;
		rcnt_d = tick ? rcnt_q + 4'h1 : rcnt_q;
		rmid = tick & (rcnt_q == OS_LAST);
		case (rst_q)
		RX_IDLE: if (rprev_q & ~rx_in & ctl_q.module_en & ctl_q.rx_en) begin
			rst_d = RX_START;
			rcnt_d = '0;
			rsh_d = '0;
			rpe_d = 1'b0;
			rpb_d = 1'b0;
		end
		RX_START: if (tick & (rcnt_q == START_CHECK)) begin
			rst_d = rx_in ? RX_IDLE : RX_DATA; // see R13
			rcnt_d = '0;
			rbit_d = '0;
		end
		RX_DATA: if (rmid) begin
			rsh_d[rbit_q] = rx_in; // see R14
			rbit_d = rbit_q + 3'd1;
			if (rbit_q == 3'd4 + {1'b0, cfg_q.lcr.wlen})
				rst_d = cfg_q.lcr.par_en ? RX_PAR : RX_STOP;
		end
		RX_PAR: if (rmid) begin
			rst_d = RX_STOP;
			rpb_d = rx_in;
			rpe_d = rx_in != par_bit(rsh_q, cfg_q.lcr); // see R14
		end
		RX_STOP: if (rmid) begin
			rst_d = RX_IDLE;
			rxw_v_d = 1'b1;
			rxw_d.data = rsh_q;
			rxw_d.fr = ~rx_in; // see R15
			rxw_d.par = rpe_q;
			rxw_d.brk = ~rx_in & (rsh_q == '0) & ~rpb_q; // see R16
			rxw_d.ovr = ovr_pend_q;
		end
		default: rst_d = RX_IDLE;
		endcase
		// full fifo keeps its words; the new one is lost
		ovr_pend_d = ovr_pend_q;
		if (rxw_v_q & rxf_ir)
			ovr_pend_d = 1'b0;
		if (rxw_v_q & ~rxf_ir)
			ovr_pend_d = 1'b1; // see R27
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sync_q <= 3'h7;
			rl_q <= 1'b1;
			rprev_q <= 1'b1;
			rst_q <= RX_IDLE;
			rcnt_q <= '0;
			rbit_q <= '0;
			rsh_q <= '0;
			rpe_q <= 1'b0;
			rpb_q <= 1'b0;
			rxw_v_q <= 1'b0;
			rxw_q <= '0;
			ovr_pend_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[1:0], serial_rx_in};
			rl_q <= rl_d;
			rprev_q <= rx_in;
			rst_q <= rst_d;
			rcnt_q <= rcnt_d;
			rbit_q <= rbit_d;
			rsh_q <= rsh_d;
			rpe_q <= rpe_d;
			rpb_q <= rpb_d;
			rxw_v_q <= rxw_v_d;
			rxw_q <= rxw_d;
			ovr_pend_q <= ovr_pend_d;
		end
	end

	// ----------------------------------------
	// flags, timeout and interrupt
	// ----------------------------------------
	usf_flag_s flags_q, flags_d;
	logic [IRQ_N-1:0] ris_q, ris_d, set;
	logic [RT_W-1:0] rt_q, rt_d;
	logic ovs_q, ovs_d, irq_q, irq_d, txh_q, rxh_q, txh, rxh, rx_empty;

	function automatic logic [LW-1:0] trig(input logic [2:0] s);
		case (s)
		LVL_1_8: trig = LW'(DEPTH / 8);
		LVL_1_4: trig = LW'(DEPTH / 4);
		LVL_3_4: trig = LW'(DEPTH * 3 / 4);
		LVL_7_8: trig = LW'(DEPTH * 7 / 8);
		default: trig = LW'(DEPTH / 2);
		endcase
	endfunction

	always_comb begin
		rx_empty = ~rxf_ov & ~rd_valid;
		flags_d.busy = txf_ov | (tst_q != TX_IDLE); // see R12
		flags_d.tx_fifo_empty_flag = ~txf_ov; // see R19
		flags_d.tx_fifo_full_flag = ~tx_wready;
		flags_d.rx_fifo_empty_flag = rx_empty;
		flags_d.rx_fifo_full_flag = ~rxf_ir;
		ovs_d = (ovs_q & ~err_clear) | (rxw_v_q & ~rxf_ir); // see R19
		txh = tx_lvl <= trig(lvl_q.tx_sel); // see R20
		rxh = rx_lvl >= trig(lvl_q.rx_sel);
		// timeout counts idle ticks while a word waits
		rt_d = rt_q;
		if (rx_empty | rxw_v_q | rst_q != RX_IDLE)
			rt_d = '0;
		else if (tick & rt_q != RT_LAST)
			rt_d = rt_q + 1'b1;
		set = '0;
		set[IRQ_TX] = txh & ~txh_q;
		set[IRQ_RX] = rxh & ~rxh_q;
		set[IRQ_RT] = tick & (rt_q == RT_LAST - 1'b1); // see R24
		set[IRQ_FE] = rxw_v_q & rxw_q.fr;
		set[IRQ_PE] = rxw_v_q & rxw_q.par;
		set[IRQ_BE] = rxw_v_q & rxw_q.brk;
		set[IRQ_OE] = rxw_v_q & ~rxf_ir;
		// a new event outranks a clear in the same cycle
		ris_d = (ris_q & ~irq_clear) | set; // see R25
		if (rx_empty)
			ris_d[IRQ_RT] = 1'b0; // see R24
		irq_d = |(ris_q & irq_mask); // see R23
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			flags_q <= '{busy: 1'b0, rx_fifo_full_flag: 1'b0, tx_fifo_empty_flag: 1'b1, tx_fifo_full_flag: 1'b0,
				rx_fifo_empty_flag: 1'b1};
			ris_q <= '0;
			rt_q <= '0;
			ovs_q <= 1'b0;
			irq_q <= 1'b0;
			txh_q <= 1'b0;
			rxh_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			ris_q <= ris_d;
			rt_q <= rt_d;
			ovs_q <= ovs_d;
			irq_q <= irq_d;
			txh_q <= txh;
			rxh_q <= rxh;
		end
	end

	assign flags = flags_q;
	assign raw_irq = ris_q;
	assign irq = irq_q;
	assign overrun_status = ovs_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_frame_start;
		tx_pop ##1 (tst_q == TX_START && txo_q == 1'b0);
	endsequence

	chk_tx_start: assert property (tx_pop |-> s_frame_start) // see R09
		else $error("frame did not begin with start bit");
	chk_busy_flag: assert property (txf_ov |=> flags_q.busy) // see R12
		else $error("busy low with data waiting");
	chk_cfg_latch: assert property (!lcr_we |=> $stable(cfg_q)) // see R04
		else $error("config moved without line write");
	chk_false_start: assert property ((rst_q == RX_START && tick
		&& rcnt_q == START_CHECK && rx_in) |=> rst_q == RX_IDLE) // see R13
		else $error("false start not dropped");
	chk_frame_error: assert property ((rst_q == RX_STOP && rmid && !rx_in)
		|=> rxw_v_q && rxw_q.fr) // see R15
		else $error("framing error not flagged");
	chk_overrun_keep: assert property ((rxw_v_q && !rxf_ir)
		|=> ovr_pend_q && ovs_q && $stable(rx_lvl)) // see R27
		else $error("overrun not held");
	chk_irq_or: assert property (|(ris_q & irq_mask) |=> irq_q) // see R23
		else $error("masked source did not raise request");
	chk_clear_bit: assert property ((irq_clear[IRQ_FE] && !set[IRQ_FE])
		|=> !ris_q[IRQ_FE]) // see R25
		else $error("clear bit ignored");
endmodule

// ===== testbench/usf_remote.sv
/*
 * remote serial device: sends frames to the port, catches its frames.
 * assumes a bit time of BIT clocks and an idle-high line.
 */
`timescale 1ns/1ps
module usf_remote #(
	parameter int BIT = 48
) (
	// clock
	input wire logic mclk,
	// serial lines
	input wire logic line_in,
	output logic line_out
);
	// ----------------------------------------
	// sending side
	// ----------------------------------------
	// idle high, as a pulled-up line sits
	initial line_out = 1'b1;

	task automatic hold(input logic v, input int c);
		line_out <= v;
		repeat (c) @(posedge mclk);
	endtask

	task automatic send(input logic [7:0] d, input int n,
		input logic pe, pv, st, two);
		@(posedge mclk);
		hold(1'b0, BIT);
		for (int i = 0; i < n; i++)
			hold(d[i], BIT);
		if (pe)
			hold(pv, BIT);
		hold(st, BIT);
		if (two)
			hold(1'b1, BIT);
		line_out <= 1'b1;
	endtask

	// ----------------------------------------
	// catching side
	// ----------------------------------------
	// mid-bit sampling; tick jitter stays far below half a bit
	task automatic catch(output logic [7:0] d, input int n,
		input logic pe, two, output logic pv, st);
		int k;
		d = 8'h00;
		pv = 1'b0;
		k = 0;
		while (line_in !== 1'b0 && k < 4000) begin
			@(negedge mclk);
			k++;
		end
		repeat (BIT / 2) @(negedge mclk);
		for (int i = 0; i < n; i++) begin
			repeat (BIT) @(negedge mclk);
			d[i] = line_in;
		end
		if (pe) begin
			repeat (BIT) @(negedge mclk);
			pv = line_in;
		end
		repeat (BIT) @(negedge mclk);
		st = line_in;
		if (two) begin
			repeat (BIT) @(negedge mclk);
			st = st & line_in;
		end
	endtask
endmodule

// ===== testbench/usf_uart_bench.sv
/*
 * bench for usf_uart: frames, errors, fifo fill, overrun, loopback.
 * assumes the remote model on the serial pins and divisor 3.
 */
`timescale 1ns/1ps
module usf_uart_bench import usf_pkg::*; ;
	localparam int BIT = 16 * 3;
	logic mclk, resetn, tx_wvalid, tx_wready, rd_valid, rd_ready;
	logic int_div_we, frac_div_we, lcr_we, ctl_we, lvl_we, err_clear;
	logic [DATA_W-1:0] tx_wdata;
	logic [DIV_INT_W-1:0] int_div_wdata;
	logic [DIV_FRAC_W-1:0] frac_div_wdata;
	logic [IRQ_N-1:0] irq_mask, irq_clear, raw_irq;
	logic irq, overrun_status, rx_line, tx_line;
	usf_lcr_s lcr_wdata;
	usf_ctl_s ctl_wdata;
	usf_lvl_s lvl_wdata;
	usf_rxw_s rd_word;
	usf_flag_s flags;
	int miscompares, cmp_count;

	usf_uart DUT (.mclk, .resetn, .tx_wvalid, .tx_wdata, .tx_wready,
		.rd_valid, .rd_word, .rd_ready, .int_div_we, .int_div_wdata,
		.frac_div_we, .frac_div_wdata, .lcr_we, .lcr_wdata, .ctl_we,
		.ctl_wdata, .lvl_we, .lvl_wdata, .irq_mask, .irq_clear,
		.err_clear, .raw_irq, .irq, .flags, .overrun_status,
		.serial_rx_in(rx_line), .serial_tx_out(tx_line));
	usf_remote #(.BIT(BIT)) peer (.mclk, .line_in(tx_line),
		.line_out(rx_line));

	task automatic chk(input string w, input logic [11:0] e, g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", w, e, g);
		end
	endtask

	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic ctl(input logic [3:0] c);
		@(posedge mclk);
		ctl_we <= 1'b1;
		ctl_wdata <= c;
		@(posedge mclk);
		ctl_we <= 1'b0;
	endtask

	task automatic cfg(input logic [7:0] l, input logic [3:0] c);
		ctl(4'h6);
		@(posedge mclk);
		int_div_we <= 1'b1;
		int_div_wdata <= 16'h0003;
		frac_div_we <= 1'b1;
		frac_div_wdata <= 6'h00;
		@(posedge mclk);
		int_div_we <= 1'b0;
		frac_div_we <= 1'b0;
		lcr_we <= 1'b1;
		lcr_wdata <= l;
		@(posedge mclk);
		lcr_we <= 1'b0;
		ctl(c);
	endtask

	task automatic push(input logic [7:0] d);
		@(posedge mclk);
		tx_wvalid <= 1'b1;
		tx_wdata <= d;
		@(posedge mclk);
		tx_wvalid <= 1'b0;
	endtask

	task automatic take(input int lim, output usf_rxw_s w);
		int k;
		k = 0;
		@(negedge mclk);
		while (rd_valid !== 1'b1 && k < lim) begin
			@(negedge mclk);
			k++;
		end
		w = rd_word;
		@(posedge mclk);
		rd_ready <= 1'b1;
		@(posedge mclk);
		rd_ready <= 1'b0;
	endtask

	task automatic idle(input int lim, output int k);
		k = 0;
		while (flags.busy !== 1'b0 && k < lim) begin
			@(negedge mclk);
			k++;
		end
		chk("busy end", 12'h000, flags.busy);
	endtask

	task automatic frame_case(input logic [7:0] l, d);
		int n, k;
		logic [7:0] mk, m, got;
		logic p, gp, gs;
		usf_rxw_s w;
		n = l[6:5] + 5;
		mk = 8'hff >> (3 - l[6:5]);
		m = d & mk;
		p = l[7] ? ~l[2] : (l[2] ? ^m : ~^m);
		cfg(l, 4'h7);
		push(d);
		repeat (2) @(negedge mclk);
		chk("busy", 12'h001, flags.busy);
		peer.catch(got, n, l[1], l[3], gp, gs);
		chk("tx data", m, got);
		chk("tx parity", l[1] & p, l[1] & gp);
		chk("tx stop", 12'h001, gs);
		idle(4 * BIT, k);
		peer.send(d, n, l[1], p, 1'b1, l[3]);
		take(4 * BIT, w);
		chk("rx word", {4'h0, m}, w);
		// inverted data flips parity for odd lengths; send the wrong one
		peer.send(~d, n, l[1], ~(p ^ (n[0] & ~l[7])), 1'b0, 1'b0);
		take(4 * BIT, w);
		chk("rx err", {2'h1, l[1], 1'b0, ~d & mk}, w);
		$display("frame case %h done", l);
	endtask

	task automatic fill_test;
		int n, k;
		n = 0;
		cfg(8'h70, 4'h6);
		@(posedge mclk);
		tx_wvalid <= 1'b1;
		tx_wdata <= 8'h00;
		repeat (20) begin
			@(negedge mclk);
			if (tx_wready === 1'b1)
				n++;
			@(posedge mclk);
			tx_wdata <= 8'(n);
		end
		tx_wvalid <= 1'b0;
		chk("fill count", 12'h010, n);
		@(negedge mclk);
		chk("tx full", 12'h001, flags.tx_fifo_full_flag);
		ctl(4'h7);
		repeat (240) @(posedge mclk);
		ctl(4'h6);
		repeat (100) @(negedge mclk);
		chk("finish char", 12'h000, tx_line);
		repeat (170) @(negedge mclk);
		chk("stopped", 12'h001, tx_line);
		chk("busy held", 12'h001, flags.busy);
		ctl(4'h7);
		idle(8000, k);
		// word 0 went out before the stop, 15 remain
		chk("burst", 12'h001, k > 7200 && k < 7500);
		chk("tx empty", 12'h001, flags.tx_fifo_empty_flag);
		$display("fill test done");
	endtask

	task automatic overrun_test;
		usf_rxw_s w;
		cfg(8'h60, 4'h7);
		for (int i = 0; i < 5; i++)
			peer.send(8'h10 + 8'(i), 8, 1'b0, 1'b0, 1'b1, 1'b0);
		repeat (20) @(negedge mclk);
		chk("overrun", 12'h001, overrun_status);
		chk("overrun raw", 12'h001, raw_irq[IRQ_OE]);
		chk("rx full", 12'h001, flags.rx_fifo_full_flag);
		repeat (1580) @(negedge mclk);
		chk("rx timeout", 12'h001, raw_irq[IRQ_RT]);
		@(posedge mclk);
		irq_mask <= 7'h40;
		irq_clear <= 7'h48;
		@(posedge mclk);
		irq_clear <= 7'h00;
		@(negedge mclk);
		chk("irq out", 12'h001, irq);
		chk("irq clear", 12'h000, raw_irq & 7'h48);
		take(10, w);
		chk("kept word", 12'h010, w);
		take(10, w);
		chk("kept word", 12'h011, w);
		take(10, w);
		chk("kept word", 12'h012, w);
		@(posedge mclk);
		rd_ready <= 1'b1;
		err_clear <= 1'b1;
		@(posedge mclk);
		err_clear <= 1'b0;
		repeat (10) @(posedge mclk);
		rd_ready <= 1'b0;
		@(negedge mclk);
		chk("rx empty", 12'h001, flags.rx_fifo_empty_flag);
		chk("ovr clear", 12'h000, overrun_status);
		chk("timeout clear", 12'h000, raw_irq[IRQ_RT]);
		@(posedge mclk);
		peer.hold(1'b0, 12);
		// wait past a whole frame, so an accepted start would show
		peer.hold(1'b1, 12 * BIT);
		chk("false start", 12'h000, rd_valid);
		peer.send(8'h00, 8, 1'b0, 1'b0, 1'b0, 1'b0);
		take(4 * BIT, w);
		chk("break", 12'hd00, w);
		cfg(8'h60, 4'hf);
		push(8'h3c);
		take(20 * BIT, w);
		chk("loopback", 12'h03c, w);
		$display("overrun test done");
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial begin
		miscompares = 0;
		cmp_count = 0;
		resetn = 1'b0;
		{tx_wvalid, rd_ready, int_div_we, frac_div_we, lcr_we, ctl_we,
			lvl_we, err_clear, tx_wdata, int_div_wdata, frac_div_wdata,
			lcr_wdata, ctl_wdata, lvl_wdata, irq_mask, irq_clear} = '0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		chk("reset flags", 12'h005, flags);
		chk("reset line", 12'h001, tx_line);
		chk("reset ready", 12'h001, tx_wready);
		$display("reset test done");
		frame_case(8'h10, 8'hc5);
		frame_case(8'h36, 8'hc4);
		frame_case(8'h5a, 8'hc7);
		frame_case(8'hf6, 8'hc6);
		fill_test;
		overrun_test;
		test_done;
	end

	initial begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		$display("watchdog expired");
		test_done;
	end
endmodule
